/* File: include/fcs_regs.svh */
// Register offsets, field positions, command codes and counts of the flash sequencer
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_CTRL0_OFS 16'h0000
`define FCS_CTRL1_OFS 16'h0004
`define FCS_WIN_BIT 15
`define FCS_C0_READY 0
`define FCS_C0_REWRITE 1
`define FCS_C0_LOCKDIS 2
`define FCS_C0_PERR 6
`define FCS_C0_EERR 7
`define FCS_C1_EW1 1
`define FCS_C1_LOCKRES 6
`define FCS_SR_READY 7
`define FCS_SR_EERR 5
`define FCS_SR_PERR 4
`define FCS_CMD_RDARR 8'hff
`define FCS_CMD_RDSTAT 8'h70
`define FCS_CMD_CLRSTAT 8'h50
`define FCS_CMD_PROG 8'h40
`define FCS_CMD_ERASE 8'h20
`define FCS_CMD_ERALL 8'ha7
`define FCS_CMD_LOCKPRG 8'h77
`define FCS_CMD_LOCKRD 8'h71
`define FCS_CMD_CONFIRM 8'hd0
`define FCS_LOCK_CYC 4'h4
`define FCS_ERASED_WORD 16'hffff
`endif

/* File: include/fcs_pkg.sv */
// Types of the flash command sequencer
package fcs_pkg;
	typedef enum logic [2:0] {
		FCS_IDLE,
		FCS_SECOND,
		FCS_PROG_RD,
		FCS_PROG_WR,
		FCS_ERASE,
		FCS_LOCK_OP
	} fcs_state_t;
	typedef enum logic {
		FCS_RD_ARRAY,
		FCS_RD_STATUS
	} fcs_rdmode_t;
endpackage

/* File: include/fcs_mem_if.sv */
// Port between the sequencer and the flash array
`timescale 1ns/1ps
interface fcs_mem_if #(
	parameter int AW = 8,
	parameter int DW = 16
);
	logic [AW-1:0] addr;
	logic          wr_en;
	logic [DW-1:0] wr_data;
	logic [DW-1:0] rd_data;
	modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
	modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface

/* File: hdl/fcs_mem.sv */
// Flash array model with registered read data
`timescale 1ns/1ps
module fcs_mem #(
	parameter int AW    = 8,
	parameter int DW    = 16,
	parameter int DEPTH = 224
) (
	input wire logic clk_i, // System clock
	fcs_mem_if.mem   port_io // Array port
);
	logic [DW-1:0] cells [DEPTH];
	logic [DW-1:0] rd_q;

	if (DEPTH > 2**AW || DEPTH < 1)
	begin : g_chk
		$error("fcs_mem: DEPTH does not fit AW");
	end

	always_ff @(posedge clk_i)
	begin
		if (port_io.wr_en)
			cells[port_io.addr] <= port_io.wr_data;
		rd_q <= cells[port_io.addr];
	end

	assign port_io.rd_data = rd_q;
endmodule // fcs_mem

/* File: hdl/fcs_top.sv */
// Flash command sequencer with classic Wishbone register and array window
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_top #(
	parameter int WORDS_PER_BLOCK = 16,
	parameter int NUM_BLOCKS      = 14
) (
	input  wire logic        clk_i, // 200 MHz system clock
	input  wire logic        rst_i, // Synchronous reset, active high
	input  wire logic        cyc_i, // Wishbone cycle
	input  wire logic        stb_i, // Wishbone strobe
	input  wire logic        we_i,  // Wishbone write
	input  wire logic [15:0] adr_i, // Wishbone byte address
	input  wire logic [3:0]  sel_i, // Wishbone byte selects
	input  wire logic [31:0] dat_i, // Wishbone write data
	output logic      [31:0] dat_o, // Wishbone read data
	output logic             ack_o  // Wishbone acknowledge
);
	localparam int DEPTH = WORDS_PER_BLOCK * NUM_BLOCKS;
	localparam int AW    = $clog2(DEPTH);
	localparam int BW    = $clog2(WORDS_PER_BLOCK);
	localparam int NBW   = AW - BW;
	localparam logic [NBW-1:0] LAST_ALL = NBW'(NUM_BLOCKS - 2);

	if (NUM_BLOCKS < 2 || WORDS_PER_BLOCK < 2 || DEPTH > 8192
		|| WORDS_PER_BLOCK != 2**BW)
	begin : g_chk
		$error("fcs_top: unsupported flash geometry");
	end

	fcs_pkg::fcs_state_t  state_q, state_d;
	fcs_pkg::fcs_rdmode_t rdmode_q, rdmode_d;
	logic [7:0]            cmd_q, cmd_d;
	logic [AW-1:0]         addr_q, addr_d;
	logic [15:0]           wdata_q, wdata_d;
	logic [NBW-1:0]        blk_q, blk_d;
	logic [BW-1:0]         wcnt_q, wcnt_d;
	logic                  all_q, all_d;
	logic [3:0]            cnt_q, cnt_d;
	logic [NUM_BLOCKS-1:0] lock_q, lock_d;
	logic                  lres_q, lres_d;
	logic                  perr_q, eerr_q;
	logic                  rewrite_q, lockdis_q, ew1_q;
	logic                  wait_q, ack_q;
	logic [31:0]           dat_q;
	logic                  perr_set, eerr_set, err_clr;

	fcs_mem_if #(.AW(AW), .DW(16)) mif ();

	fcs_mem #(.AW(AW), .DW(16), .DEPTH(DEPTH)) u_mem (
		.clk_i   (clk_i),
		.port_io (mif.mem)
	);

	// Bus decode
	wire          req       = cyc_i & stb_i;
	wire          win       = adr_i[`FCS_WIN_BIT];
	wire [12:0]   fl_word   = adr_i[14:2];
	wire          fl_hit    = win & (fl_word < 13'(DEPTH)) & (adr_i[1:0] == 2'h0);
	wire          c0_hit    = (adr_i == `FCS_CTRL0_OFS);
	wire          c1_hit    = (adr_i == `FCS_CTRL1_OFS);
	wire          bus_wr    = req & we_i & wait_q;
	wire          bus_rd    = req & ~we_i & wait_q;
	wire          fl_cmd_wr = bus_wr & fl_hit & (&sel_i[1:0]) & rewrite_q;
	wire [7:0]    code      = dat_i[7:0];
	wire [AW-1:0] bus_addr  = fl_word[AW-1:0];
	wire [NBW-1:0] bus_blk  = bus_addr[AW-1:BW];
	wire          top_blk   = &bus_addr[BW-1:0];
	wire          err_any   = perr_q | eerr_q;
	wire          ready     = (state_q == fcs_pkg::FCS_IDLE) | (state_q == fcs_pkg::FCS_SECOND);
	wire          lock_sel  = lock_q[blk_q];
	wire          bus_lockd = ~lock_q[bus_blk] & ~lockdis_q;
	wire          cur_lockd = ~lock_sel & ~lockdis_q;
	wire [15:0]   prog_res  = mif.rd_data & wdata_q;
	wire          prog_bad  = (prog_res != wdata_q);
	wire [7:0]    status    = {ready, 1'b0, eerr_q, perr_q, 4'h0};
	wire [7:0]    ctrl0     = {eerr_q, perr_q, 3'h0, lockdis_q, rewrite_q, ready};
	wire [7:0]    ctrl1     = {1'b0, lres_q, 4'h0, ew1_q, 1'b0};

	always_comb
	begin
		state_d  = state_q;
		rdmode_d = rdmode_q;
		cmd_d    = cmd_q;
		addr_d   = addr_q;
		wdata_d  = wdata_q;
		blk_d    = blk_q;
		wcnt_d   = wcnt_q;
		all_d    = all_q;
		cnt_d    = cnt_q;
		lock_d   = lock_q;
		lres_d   = lres_q;
		perr_set = 1'b0;
		eerr_set = 1'b0;
		err_clr  = 1'b0;
		mif.addr    = bus_addr;
		mif.wr_en   = 1'b0;
		mif.wr_data = prog_res;
		unique case (state_q)
			fcs_pkg::FCS_IDLE:
				if (fl_cmd_wr)
				begin
					cmd_d  = code;
					addr_d = bus_addr;
					case (code)
						`FCS_CMD_RDARR: rdmode_d = fcs_pkg::FCS_RD_ARRAY;
						`FCS_CMD_RDSTAT: rdmode_d = fcs_pkg::FCS_RD_STATUS;
						`FCS_CMD_CLRSTAT: err_clr = 1'b1;
						`FCS_CMD_PROG, `FCS_CMD_ERASE, `FCS_CMD_ERALL, `FCS_CMD_LOCKPRG:
							if (!err_any)
								state_d = fcs_pkg::FCS_SECOND;
						`FCS_CMD_LOCKRD: state_d = fcs_pkg::FCS_SECOND;
						default:
						begin
							perr_set = 1'b1;
							eerr_set = 1'b1;
						end
					endcase
				end
			fcs_pkg::FCS_SECOND:
				if (fl_cmd_wr)
				begin
					state_d = fcs_pkg::FCS_IDLE;
					if (cmd_q == `FCS_CMD_PROG)
					begin
						if (bus_addr != addr_q)
						begin
							perr_set = 1'b1;
							eerr_set = 1'b1;
						end
						else
						begin
							wdata_d = dat_i[15:0];
							state_d = fcs_pkg::FCS_PROG_RD;
							if (!ew1_q)
								rdmode_d = fcs_pkg::FCS_RD_STATUS;
						end
					end
					else if (code == `FCS_CMD_RDARR)
						rdmode_d = fcs_pkg::FCS_RD_ARRAY;
					else if (code != `FCS_CMD_CONFIRM
						|| (cmd_q != `FCS_CMD_ERALL && !top_blk)
						|| (cmd_q == `FCS_CMD_LOCKPRG && bus_addr != addr_q))
					begin
						perr_set = 1'b1;
						eerr_set = 1'b1;
					end
					else
					begin
						blk_d  = bus_blk;
						wcnt_d = '0;
						all_d  = 1'b0;
						cnt_d  = `FCS_LOCK_CYC;
						if (cmd_q != `FCS_CMD_LOCKRD && !ew1_q)
							rdmode_d = fcs_pkg::FCS_RD_STATUS;
						case (cmd_q)
							`FCS_CMD_ERASE:
								if (bus_lockd)
									eerr_set = 1'b1;
								else
									state_d = fcs_pkg::FCS_ERASE;
							`FCS_CMD_ERALL:
							begin
								all_d   = 1'b1;
								blk_d   = '0;
								state_d = fcs_pkg::FCS_ERASE;
							end
							`FCS_CMD_LOCKRD:
							begin
								rdmode_d = fcs_pkg::FCS_RD_ARRAY;
								state_d  = fcs_pkg::FCS_LOCK_OP;
							end
							default: state_d = fcs_pkg::FCS_LOCK_OP;
						endcase
					end
				end
			fcs_pkg::FCS_PROG_RD:
			begin
				mif.addr = addr_q;
				state_d  = fcs_pkg::FCS_PROG_WR;
			end
			fcs_pkg::FCS_PROG_WR:
			begin
				mif.addr  = addr_q;
				mif.wr_en = ~(~lock_q[addr_q[AW-1:BW]] & ~lockdis_q);
				perr_set  = prog_bad | ~mif.wr_en;
				state_d   = fcs_pkg::FCS_IDLE;
			end
			fcs_pkg::FCS_ERASE:
			begin
				mif.addr    = {blk_q, wcnt_q};
				mif.wr_data = `FCS_ERASED_WORD;
				mif.wr_en   = ~(all_q & cur_lockd);
				wcnt_d      = BW'(wcnt_q + 1'b1);
				if ((all_q && cur_lockd) || &wcnt_q)
				begin
					wcnt_d = '0;
					if (!cur_lockd)
						lock_d[blk_q] = 1'b1;
					if (!all_q || blk_q == LAST_ALL)
						state_d = fcs_pkg::FCS_IDLE;
					else
						blk_d = NBW'(blk_q + 1'b1);
				end
			end
			fcs_pkg::FCS_LOCK_OP:
			begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1)
				begin
					state_d = fcs_pkg::FCS_IDLE;
					if (cmd_q == `FCS_CMD_LOCKPRG)
						lock_d[blk_q] = 1'b0;
					else
						lres_d = lock_sel;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q  <= fcs_pkg::FCS_IDLE;
			rdmode_q <= fcs_pkg::FCS_RD_ARRAY;
			cmd_q    <= 8'h00;
			addr_q   <= '0;
			wdata_q  <= 16'h0000;
			blk_q    <= '0;
			wcnt_q   <= '0;
			all_q    <= 1'b0;
			cnt_q    <= 4'h0;
			lock_q   <= '1;
			lres_q   <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			rdmode_q <= rdmode_d;
			cmd_q    <= cmd_d;
			addr_q   <= addr_d;
			wdata_q  <= wdata_d;
			blk_q    <= blk_d;
			wcnt_q   <= wcnt_d;
			all_q    <= all_d;
			cnt_q    <= cnt_d;
			lock_q   <= lock_d;
			lres_q   <= lres_d;
		end
	end

	// Error flags: a set in the same cycle beats a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
		end
		else
		begin
			perr_q <= (perr_q & ~err_clr) | perr_set;
			eerr_q <= (eerr_q & ~err_clr) | eerr_set;
		end
	end

	// Control bits and bus handshake
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rewrite_q <= 1'b0;
			lockdis_q <= 1'b0;
			ew1_q     <= 1'b0;
			wait_q    <= 1'b0;
			ack_q     <= 1'b0;
			dat_q     <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= req & ~wait_q & ~ack_q;
			ack_q  <= wait_q & req;
			if (bus_wr && c0_hit && sel_i[0])
			begin
				rewrite_q <= dat_i[`FCS_C0_REWRITE];
				lockdis_q <= dat_i[`FCS_C0_LOCKDIS];
			end
			if (bus_wr && c1_hit && sel_i[0])
				ew1_q <= dat_i[`FCS_C1_EW1];
			if (bus_rd)
				dat_q <= c0_hit ? {24'h0, ctrl0} :
					c1_hit ? {24'h0, ctrl1} :
					!fl_hit ? 32'h0 :
					rdmode_q == fcs_pkg::FCS_RD_STATUS ? {24'h0, status} :
					{16'h0, mif.rd_data};
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wire idle_wr = (state_q == fcs_pkg::FCS_IDLE) & fl_cmd_wr;
	wire sec_wr  = (state_q == fcs_pkg::FCS_SECOND) & fl_cmd_wr;

	chk_array_mode: assert property (idle_wr && code == `FCS_CMD_RDARR |=>
		rdmode_q == fcs_pkg::FCS_RD_ARRAY) else $error("array mode not entered");
	chk_array_holds: assert property (rdmode_q == fcs_pkg::FCS_RD_ARRAY && !fl_cmd_wr
		&& state_q == fcs_pkg::FCS_IDLE |=> rdmode_q == fcs_pkg::FCS_RD_ARRAY)
		else $error("array mode lost without command");
	chk_status_mode: assert property (idle_wr && code == `FCS_CMD_RDSTAT |=>
		rdmode_q == fcs_pkg::FCS_RD_STATUS) else $error("status mode not entered");
	chk_clear_errors: assert property (idle_wr && code == `FCS_CMD_CLRSTAT |=>
		!perr_q && !eerr_q) else $error("error flags not cleared");
	chk_prog_busy: assert property (sec_wr && cmd_q == `FCS_CMD_PROG && bus_addr == addr_q
		|=> !ready ##1 !ready ##1 ready) else $error("program busy window wrong");
	chk_prog_verify: assert property (state_q == fcs_pkg::FCS_PROG_WR && prog_bad
		|=> perr_q) else $error("program error not flagged");
	chk_ew0_status: assert property (sec_wr && cmd_q == `FCS_CMD_PROG && !ew1_q
		&& bus_addr == addr_q |=> rdmode_q == fcs_pkg::FCS_RD_STATUS && !status[7])
		else $error("status mode not taken at program start");
	chk_erase_busy: assert property (state_q == fcs_pkg::FCS_ERASE |-> !ready)
		else $error("ready high during erase");
	chk_erase_range: assert property (state_q == fcs_pkg::FCS_ERASE && all_q
		|-> blk_q <= LAST_ALL) else $error("erase all reached block A");
	chk_lock_prog: assert property (state_q == fcs_pkg::FCS_LOCK_OP && cnt_q == 4'h1
		&& cmd_q == `FCS_CMD_LOCKPRG |=> !lock_sel) else $error("lock bit not cleared");
	chk_lock_read: assert property (state_q == fcs_pkg::FCS_LOCK_OP && cnt_q == 4'h1
		&& cmd_q == `FCS_CMD_LOCKRD |=> lres_q == $past(lock_sel))
		else $error("lock result wrong");
	chk_reject_err: assert property (idle_wr && err_any && code == `FCS_CMD_PROG
		|=> state_q == fcs_pkg::FCS_IDLE) else $error("command taken with error set");
	chk_seq_error: assert property (sec_wr && cmd_q != `FCS_CMD_PROG
		&& code != `FCS_CMD_CONFIRM && code != `FCS_CMD_RDARR |=> perr_q && eerr_q)
		else $error("sequence error not flagged");
	chk_cancel_ff: assert property (sec_wr && cmd_q != `FCS_CMD_PROG && code == `FCS_CMD_RDARR
		|=> state_q == fcs_pkg::FCS_IDLE && rdmode_q == fcs_pkg::FCS_RD_ARRAY)
		else $error("cancel did not return to array mode");
	chk_locked_erase: assert property (sec_wr && cmd_q == `FCS_CMD_ERASE
		&& code == `FCS_CMD_CONFIRM && top_blk && bus_lockd
		|=> eerr_q && state_q == fcs_pkg::FCS_IDLE) else $error("locked block erased");

	cov_program: cover property (state_q == fcs_pkg::FCS_PROG_WR);
	cov_erase_all: cover property (state_q == fcs_pkg::FCS_ERASE && all_q && blk_q == LAST_ALL);
	cov_lock_read: cover property (state_q == fcs_pkg::FCS_LOCK_OP && cmd_q == `FCS_CMD_LOCKRD);
endmodule // fcs_top

/* File: sim/fcs_cpu_model.sv */
// Wishbone master standing in for the CPU running the rewrite program
`timescale 1ns/1ps
module fcs_cpu_model (
	input  wire logic        clk_i,    // System clock
	input  wire logic        rst_i,    // Synchronous reset
	input  wire logic        go_i,     // Start one access
	input  wire logic        go_we_i,  // Access is a write
	input  wire logic [15:0] go_adr_i, // Access byte address
	input  wire logic [31:0] go_dat_i, // Access write data
	input  wire logic        ack_i,    // Slave acknowledge
	input  wire logic [31:0] rd_i,     // Slave read data
	output logic             cyc_o,    // Wishbone cycle
	output logic             stb_o,    // Wishbone strobe
	output logic             we_o,     // Wishbone write
	output logic      [15:0] adr_o,    // Wishbone address
	output logic      [3:0]  sel_o,    // Wishbone byte selects
	output logic      [31:0] dat_o,    // Wishbone write data
	output logic             done_o,   // Access finished
	output logic      [31:0] rdat_o    // Data taken at ack
);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{cyc_o, stb_o, we_o, done_o} <= 4'h0;
			{adr_o, sel_o, dat_o, rdat_o} <= '0;
		end
		else
		begin
			done_o <= 1'b0;
			if (cyc_o && ack_i)
			begin
				// Released address and data lines show no stale value
				{cyc_o, stb_o} <= 2'b00;
				rdat_o <= rd_i;
				done_o <= 1'b1;
				adr_o <= ~adr_o;
				dat_o <= ~dat_o;
			end
			else if (!cyc_o && go_i)
			begin
				{cyc_o, stb_o} <= 2'b11;
				we_o <= go_we_i;
				adr_o <= {go_adr_i[15:2], 2'b00};
				sel_o <= 4'h3;
				dat_o <= go_dat_i;
			end
		end
	end
endmodule // fcs_cpu_model

/* File: sim/test_flash_command_sequencer.sv */
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "fcs_regs.svh"
module test_flash_command_sequencer;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        go = 1'b0, gw = 1'b0, done, cyc, stb, we, ack;
	logic [15:0] ga = 16'h0, adr;
	logic [31:0] gd = 32'h0, wdat, rdat, rd, seed = 32'hcf3b;
	logic [3:0]  sel;
	logic [15:0] mem [224];
	logic        lk [14];
	logic        pe = 1'b0, ee = 1'b0;
	int          fails = 0, tests_run = 0;

	always #2.5 clk_i = ~clk_i;

	fcs_cpu_model u_fcs_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .go_we_i(gw),
		.go_adr_i(ga), .go_dat_i(gd), .ack_i(ack), .rd_i(rd), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .done_o(done), .rdat_o(rdat));
	fcs_top u_fcs_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rd), .ack_o(ack));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk_i);
		go <= 1'b1;
		gw <= w;
		ga <= a;
		gd <= d;
		@(posedge clk_i);
		go <= 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 50)
		begin
			@(posedge clk_i);
			#1;
			i++;
		end
		if (i == 50)
		begin
			fails++;
			final_report();
		end
		q = rdat;
	endtask

	task automatic fw(input int n, input logic [7:0] c);
		logic [31:0] q;
		seed = lfsr(seed);
		// Random upper byte must not matter
		bus(1'b1, 16'h8000 + 16'(n * 4), {16'h0, seed[7:0], c}, q);
	endtask

	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_reg(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp("register", e, q & m);
	endtask

	task automatic chk_arr(input int n);
		logic [31:0] q;
		bus(1'b0, 16'h8000 + 16'(n * 4), 32'h0, q);
		cmp("array word", {16'h0, mem[n]}, {16'h0, q[15:0]});
	endtask

	task automatic chk_sr(input logic r);
		logic [31:0] q;
		bus(1'b0, 16'h8000, 32'h0, q);
		cmp("status byte", {24'h0, r, 1'b0, ee, pe, 4'h0}, {24'h0, q[7:0]});
	endtask

	function automatic logic [31:0] c0(input logic r);
		return {24'h0, ee, pe, 4'h0, 1'b1, r};
	endfunction

	task automatic wait_ready();
		int i;
		logic [31:0] q;
		for (i = 0; i < 100; i++)
		begin
			bus(1'b0, `FCS_CTRL0_OFS, 32'h0, q);
			if (q[0] === 1'b1)
				break;
		end
		if (i == 100)
		begin
			fails++;
			final_report();
		end
	endtask

	task automatic erase(input int b);
		for (int n = b * 16; n < b * 16 + 16; n++)
			mem[n] = `FCS_ERASED_WORD;
		lk[b] = 1'b1;
	endtask

	task automatic program_word(input int n);
		logic [31:0] q;
		seed = lfsr(seed);
		mem[n] = seed[15:0];
		fw(n, `FCS_CMD_PROG);
		bus(1'b1, 16'h8000 + 16'(n * 4), {16'h0, mem[n]}, q);
		if (pe || ee)
			mem[n] = 16'hffff;
		wait_ready();
	endtask

	initial
	begin
		logic [31:0] q;
		for (int b = 0; b < 14; b++)
			lk[b] = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, 32'h1);
		chk_reg(16'h0010, 32'hffffffff, 32'h0);
		bus(1'b1, `FCS_CTRL0_OFS, 32'h2, q);
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		$display("test 1 done");
		for (int k = 0; k < 2; k++)
		begin
			fw(0, `FCS_CMD_ERASE);
			fw(k * 208 + 15, `FCS_CMD_CONFIRM);
			erase(k * 13);
			chk_sr(1'b0);
			wait_ready();
			chk_sr(1'b1);
			fw(0, `FCS_CMD_RDARR);
			chk_arr(k * 208 + 5);
		end
		$display("test 2 done");
		for (int k = 3; k <= 208; k += 205)
		begin
			program_word(k);
			chk_sr(1'b1);
			cmp("program error", 32'h0, {31'h0, pe});
			fw(0, `FCS_CMD_RDARR);
			chk_arr(k);
			chk_arr(k + 1);
		end
		fw(0, `FCS_CMD_RDSTAT);
		chk_sr(1'b1);
		$display("test 3 done");
		fw(0, `FCS_CMD_ERASE);
		fw(15, 8'h55);
		{pe, ee} = 2'b11;
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		program_word(4);
		fw(0, `FCS_CMD_RDARR);
		chk_arr(4);
		fw(0, `FCS_CMD_CLRSTAT);
		{pe, ee} = 2'b00;
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		fw(0, `FCS_CMD_ERASE);
		fw(15, `FCS_CMD_RDARR);
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		chk_arr(3);
		$display("test 4 done");
		fw(31, `FCS_CMD_LOCKPRG);
		fw(31, `FCS_CMD_CONFIRM);
		lk[1] = 1'b0;
		wait_ready();
		for (int k = 0; k < 2; k++)
		begin
			fw(0, `FCS_CMD_LOCKRD);
			fw(k * 16 + 15, `FCS_CMD_CONFIRM);
			wait_ready();
			chk_reg(`FCS_CTRL1_OFS, 32'h40, {25'h0, lk[k], 6'h0});
		end
		fw(0, `FCS_CMD_ERASE);
		fw(31, `FCS_CMD_CONFIRM);
		ee = 1'b1;
		wait_ready();
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		fw(0, `FCS_CMD_CLRSTAT);
		ee = 1'b0;
		$display("test 5 done");
		fw(0, `FCS_CMD_ERALL);
		fw(0, `FCS_CMD_CONFIRM);
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b0));
		for (int b = 0; b < 13; b++)
			if (lk[b])
				erase(b);
		wait_ready();
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, c0(1'b1));
		fw(0, `FCS_CMD_RDARR);
		for (int b = 0; b < 14; b++)
			if (b != 1)
				chk_arr(b * 16 + 3 - (b / 13) * 3);
		$display("test 6 done");
		// Flash-execution mode: program leaves array-read mode in place
		bus(1'b1, `FCS_CTRL1_OFS, 32'h2, q);
		chk_reg(`FCS_CTRL1_OFS, 32'h2, 32'h2);
		program_word(7);
		cmp("program error", 32'h0, {31'h0, pe});
		chk_arr(7);
		// Rewrite disabled as before wait mode
		bus(1'b1, `FCS_CTRL0_OFS, 32'h0, q);
		chk_reg(`FCS_CTRL0_OFS, 32'hffffffff, 32'h1);
		$display("test 7 done");
		final_report();
	end
endmodule // test_flash_command_sequencer
